// >>> timer_pkg.sv
// shared constants and types for the ten-bit standard timer
package timer_pkg;
   localparam int CNT_W = 10;
   localparam logic [7:0] ADDR_CTRL0 = 8'h00;
   localparam logic [7:0] ADDR_CTRL1 = 8'h04;
   localparam logic [7:0] ADDR_CNT_LO = 8'h08;
   localparam logic [7:0] ADDR_CNT_HI = 8'h0C;
   localparam logic [7:0] ADDR_CMP_LO = 8'h10;
   localparam logic [7:0] ADDR_CMP_HI = 8'h14;
   localparam logic [7:0] ADDR_FLAGS = 8'h18;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] MODE_CMP = 2'h0;
   localparam logic [1:0] MODE_CAP = 2'h1;
   localparam logic [1:0] MODE_PWM = 2'h2;
   localparam logic [1:0] MODE_TMR = 2'h3;
   localparam logic [2:0] CLK_SYS_DIV4 = 3'h0;
   localparam logic [2:0] CLK_SYS = 3'h1;
   localparam logic [2:0] CLK_HI_DIV16 = 3'h2;
   localparam logic [2:0] CLK_HI_DIV64 = 3'h3;
   localparam logic [2:0] CLK_TBC = 3'h4;
   localparam logic [2:0] CLK_EXT_RISE = 3'h6;
   localparam logic [2:0] CLK_EXT_FALL = 3'h7;
   localparam logic [5:0] DIV_MAX = 6'h3F;
   localparam logic [9:0] CNT_MAX = 10'h3FF;
   typedef struct packed {
      logic pause_ctrl;
      logic [2:0] clock_select;
      logic counter_on;
      logic [2:0] period_field;
   } ctrl0_type;
   typedef struct packed {
      logic [1:0] mode_field;
      logic [1:0] output_function;
      logic output_control;
      logic output_polarity;
      logic period_duty_swap;
      logic clear_select;
   } ctrl1_type;
   typedef struct packed {
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
   } wr_req_type;
endpackage

// >>> timer_tick.sv
// clock source selector producing a one-cycle count tick
`timescale 1ns/10ps
module timer_tick (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [2:0] clock_select,
   input wire logic high_speed_clock,
   input wire logic time_base_clock,
   input wire logic ext_clock_pin,
   output logic tick
);
   typedef struct packed {
      logic [5:0] div;
      logic [2:0] hs_sync;
      logic [2:0] tb_sync;
      logic [2:0] ext_sync;
      logic [3:0] hs_div;
      logic [5:0] hs_div64;
   } tick_state_type;
   tick_state_type s_q, s_d;
   logic hs_rise;
   logic tb_rise;
   always_comb begin
      s_d = s_q;
      s_d.div = s_q.div + 6'h01;
      s_d.hs_sync = {s_q.hs_sync[1:0], high_speed_clock};
      s_d.tb_sync = {s_q.tb_sync[1:0], time_base_clock};
      s_d.ext_sync = {s_q.ext_sync[1:0], ext_clock_pin};
      hs_rise = s_q.hs_sync[1] & ~s_q.hs_sync[2];
      tb_rise = s_q.tb_sync[1] & ~s_q.tb_sync[2];
      if (hs_rise) begin
         s_d.hs_div = s_q.hs_div + 4'h1;
         s_d.hs_div64 = s_q.hs_div64 + 6'h01;
      end
      // the reserved code yields no tick and so stops counting
      case (clock_select)
         timer_pkg::CLK_SYS_DIV4: tick = (s_q.div[1:0] == 2'h3);
         timer_pkg::CLK_SYS: tick = 1'b1;
         timer_pkg::CLK_HI_DIV16: tick = hs_rise && (s_q.hs_div == 4'hF);
         timer_pkg::CLK_HI_DIV64: tick = hs_rise && (s_q.hs_div64 == timer_pkg::DIV_MAX);
         timer_pkg::CLK_TBC: tick = tb_rise;
         timer_pkg::CLK_EXT_RISE: tick = s_q.ext_sync[1] & ~s_q.ext_sync[2];
         timer_pkg::CLK_EXT_FALL: tick = ~s_q.ext_sync[1] & s_q.ext_sync[2];
         default: tick = 1'b0;
      endcase
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// >>> timer_top.sv
// ten-bit standard timer with period and compare comparators behind AXI4-Lite
// What this block does
// - ten-bit up counter on selected clock, compared with period and compare values
// - period value matches counter bits nine to seven; compare matches all bits
// - software cannot write counter; counter zeroes on counter_on rising
// - selected match clears counter and raises a flag; overflow wraps counter to zero
// - pause holds counter value; release resumes from it
// - clock select picks divided, internal or external edge sources; reserved stops
// - counter_on low stops counting and keeps residual count
// - compare mode: counter_on rising restores pin to initial level
// - period field counts in 128 clocks; zero means 1024
// - clear_select zero: period match clears; zero period clears by overflow
// - mode field: compare, capture, PWM or single pulse, timer
// - compare match action: keep, low, high, toggle
// - PWM mode function: inactive, active, PWM waveform, single pulse
// - capture edge: rising, falling, both, disabled
// - pin changes only when requested level differs from present level
// - output_control gives initial level or PWM active level
// - output_polarity inverts both pins in every mode, timer mode included
// - swap bit exchanges period and duty roles in PWM
// - clear_select one: compare match clears; ignored in PWM and capture
// - one external clock input and two output pins with same function
// - clear_select one in compare or timer mode: no period flag
// - duty at or above period keeps output active whole period
`timescale 1ns/10ps
module timer_top (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic high_speed_clock,
   input wire logic time_base_clock,
   input wire logic ext_clock_pin,
   input wire logic cap_pin_a,
   input wire logic cap_pin_b,
   output logic timer_out_pin_a,
   output logic timer_out_pin_b,
   output logic timer_out_en,
   output logic compare_match_flag,
   output logic period_match_flag
);
   typedef struct packed {
      timer_pkg::ctrl0_type c0;
      timer_pkg::ctrl1_type c1;
      logic [9:0] cnt;
      logic [9:0] cmp;
      logic on_prev;
      logic pin;
      logic pulse_done;
      logic af;
      logic pf;
      logic [2:0] cap_sync_a;
      logic [2:0] cap_sync_b;
      logic aw_got;
      logic w_got;
      timer_pkg::wr_req_type wr;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic out_a;
      logic out_b;
      logic out_en;
   } state_type;
   state_type s_q, s_d;
   logic tick;
   logic on_rise;
   logic [9:0] cnt_next;
   logic match_a;
   logic match_p;
   logic [10:0] period_len;
   logic [10:0] duty_len;
   logic pwm_level;
   logic cap_edge;
   logic ea_r, ea_f, eb_r, eb_f;
   logic level;
   logic [31:0] rd;
   logic rd_ok;
   logic wr_ok;
   timer_tick u_tick (
      .mclk(mclk),
      .rst_n(rst_n),
      .clock_select(s_q.c0.clock_select),
      .high_speed_clock(high_speed_clock),
      .time_base_clock(time_base_clock),
      .ext_clock_pin(ext_clock_pin),
      .tick(tick)
   );
   //////////////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_d = s_q;
      on_rise = s_q.c0.counter_on & ~s_q.on_prev;
      s_d.on_prev = s_q.c0.counter_on;
      s_d.cap_sync_a = {s_q.cap_sync_a[1:0], cap_pin_a};
      s_d.cap_sync_b = {s_q.cap_sync_b[1:0], cap_pin_b};
      ea_r = s_q.cap_sync_a[1] & ~s_q.cap_sync_a[2];
      ea_f = ~s_q.cap_sync_a[1] & s_q.cap_sync_a[2];
      eb_r = s_q.cap_sync_b[1] & ~s_q.cap_sync_b[2];
      eb_f = ~s_q.cap_sync_b[1] & s_q.cap_sync_b[2];
      cnt_next = s_q.cnt + 10'h001;
      match_a = tick && (cnt_next == s_q.cmp);
      // a zero period field matches on the wrap to zero, so overflow raises the period flag
      match_p = tick && (cnt_next[9:7] == s_q.c0.period_field) &&
                (cnt_next[6:0] == 7'h00);
      period_len = (s_q.c0.period_field == 3'h0) ? 11'h400 :
                   {1'b0, s_q.c0.period_field, 7'h00};
      duty_len = {1'b0, s_q.cmp};
      if (s_q.c1.period_duty_swap) begin
         period_len = {1'b0, s_q.cmp};
         duty_len = (s_q.c0.period_field == 3'h0) ? 11'h400 :
                    {1'b0, s_q.c0.period_field, 7'h00};
      end
      // active while count below duty; duty at or above period stays active throughout
      pwm_level = ({1'b0, s_q.cnt} < duty_len) || (duty_len >= period_len);
      case (s_q.c1.output_function)
         2'h0: cap_edge = ea_r | eb_r;
         2'h1: cap_edge = ea_f | eb_f;
         2'h2: cap_edge = ea_r | ea_f | eb_r | eb_f;
         default: cap_edge = 1'b0;
      endcase
      s_d.af = 1'b0;
      s_d.pf = 1'b0;
      // counting: no write path to the counter, only the on-rise clear
      if (on_rise) begin
         s_d.cnt = '0;
         s_d.pulse_done = 1'b0;
         if (s_q.c1.mode_field == timer_pkg::MODE_CMP) begin
            s_d.pin = s_q.c1.output_control;
         end
      end else if (s_q.c0.counter_on && !s_q.c0.pause_ctrl && tick) begin
         s_d.cnt = cnt_next;
         case (s_q.c1.mode_field)
            timer_pkg::MODE_PWM: begin
               if ({1'b0, cnt_next} >= period_len || cnt_next == 10'h000) begin
                  s_d.cnt = '0;
                  if (s_q.c1.output_function == 2'h3) begin
                     s_d.pulse_done = 1'b1;
                  end
               end
               s_d.af = match_a;
               s_d.pf = match_p;
            end
            timer_pkg::MODE_CAP: begin
               s_d.af = match_a;
               s_d.pf = match_p;
            end
            default: begin
               if (s_q.c1.clear_select) begin
                  if (match_a) begin
                     s_d.cnt = '0;
                  end
                  s_d.af = match_a;
               end else begin
                  if (match_p) begin
                     s_d.cnt = '0;
                  end
                  s_d.af = match_a;
                  s_d.pf = match_p;
               end
               if (match_a && s_q.c1.mode_field == timer_pkg::MODE_CMP) begin
                  case (s_q.c1.output_function)
                     2'h1: s_d.pin = 1'b0;
                     2'h2: s_d.pin = 1'b1;
                     2'h3: s_d.pin = ~s_q.pin;
                     default: s_d.pin = s_q.pin;
                  endcase
               end
            end
         endcase
      end
      if (s_q.c0.counter_on && s_q.c1.mode_field == timer_pkg::MODE_CAP && cap_edge) begin
         s_d.cmp = s_q.cnt;
         s_d.af = 1'b1;
      end
      // output pin level before polarity
      case (s_q.c1.mode_field)
         timer_pkg::MODE_PWM: begin
            case (s_q.c1.output_function)
               2'h0: level = ~s_q.c1.output_control;
               2'h1: level = s_q.c1.output_control;
               2'h2: level = pwm_level ? s_q.c1.output_control : ~s_q.c1.output_control;
               default: level = (s_q.c0.counter_on && !s_q.pulse_done && pwm_level) ?
                                s_q.c1.output_control : ~s_q.c1.output_control;
            endcase
         end
         default: level = s_q.pin;
      endcase
      s_d.out_a = level ^ s_q.c1.output_polarity;
      s_d.out_b = level ^ s_q.c1.output_polarity;
      s_d.out_en = (s_q.c1.mode_field == timer_pkg::MODE_CMP) ||
                   (s_q.c1.mode_field == timer_pkg::MODE_PWM);
      //////////////////////////////////////////////////////////////////////////////////////////
      // write channel: address and data taken in either order
      if (s_axi_awvalid && !s_q.aw_got && !s_q.bvalid) begin
         s_d.aw_got = 1'b1;
         s_d.wr.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_q.w_got && !s_q.bvalid) begin
         s_d.w_got = 1'b1;
         s_d.wr.wdata = s_axi_wdata;
         s_d.wr.wstrb = s_axi_wstrb;
      end
      wr_ok = 1'b1;
      if (s_q.aw_got && s_q.w_got) begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         if (s_q.wr.wstrb[0]) begin
            case (s_q.wr.awaddr)
               timer_pkg::ADDR_CTRL0: s_d.c0 = s_q.wr.wdata[7:0];
               timer_pkg::ADDR_CTRL1: s_d.c1 = s_q.wr.wdata[7:0];
               timer_pkg::ADDR_CMP_LO: s_d.cmp[7:0] = s_q.wr.wdata[7:0];
               timer_pkg::ADDR_CMP_HI: s_d.cmp[9:8] = s_q.wr.wdata[1:0];
               timer_pkg::ADDR_CNT_LO, timer_pkg::ADDR_CNT_HI, timer_pkg::ADDR_FLAGS: ;
               default: wr_ok = 1'b0;
            endcase
         end else if (s_q.wr.awaddr > timer_pkg::ADDR_FLAGS || s_q.wr.awaddr[1:0] != 2'h0) begin
            wr_ok = 1'b0;
         end
         s_d.bresp = wr_ok ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      // read channel
      rd = '0;
      rd_ok = 1'b1;
      case (s_axi_araddr)
         timer_pkg::ADDR_CTRL0: rd[7:0] = s_q.c0;
         timer_pkg::ADDR_CTRL1: rd[7:0] = s_q.c1;
         timer_pkg::ADDR_CNT_LO: rd[7:0] = s_q.cnt[7:0];
         timer_pkg::ADDR_CNT_HI: rd[1:0] = s_q.cnt[9:8];
         timer_pkg::ADDR_CMP_LO: rd[7:0] = s_q.cmp[7:0];
         timer_pkg::ADDR_CMP_HI: rd[1:0] = s_q.cmp[9:8];
         timer_pkg::ADDR_FLAGS: rd[1:0] = {s_q.pf, s_q.af};
         default: rd_ok = 1'b0;
      endcase
      if (s_axi_arvalid && !s_q.rvalid) begin
         s_d.rvalid = 1'b1;
         s_d.rdata = rd;
         s_d.rresp = rd_ok ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
      end else if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
   end
   //////////////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign s_axi_awready = ~s_q.aw_got & ~s_q.bvalid;
   assign s_axi_wready = ~s_q.w_got & ~s_q.bvalid;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = ~s_q.rvalid;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   assign timer_out_pin_a = s_q.out_a;
   assign timer_out_pin_b = s_q.out_b;
   assign timer_out_en = s_q.out_en;
   assign compare_match_flag = s_q.af;
   assign period_match_flag = s_q.pf;
endmodule

// >>> timer_pins_model.sv
// far-side pin model: external count clock and capture pulses
`timescale 1ns/10ps
module timer_pins_model (
   input wire logic mclk,
   input wire logic ext_run,
   input wire logic cap_req,
   output logic ext_clock_pin,
   output logic cap_pin_a,
   output logic cap_pin_b
);
   logic [2:0] div_q = 3'h0;
   logic [2:0] cap_q = 3'h0;
   // clock toggles every four cycles while enabled, stands low otherwise
   always @(posedge mclk) begin
      div_q <= div_q + 3'h1;
      if (!ext_run)
         ext_clock_pin <= 1'b0;
      else if (div_q[1:0] == 2'h3)
         ext_clock_pin <= !ext_clock_pin;
      cap_q <= cap_req ? 3'h4 : (cap_q != 3'h0 ? cap_q - 3'h1 : 3'h0);
   end
   assign cap_pin_a = cap_q != 3'h0;
   assign cap_pin_b = cap_pin_a;
endmodule

// >>> timer_chk.sv
// port assertions for the timer
`timescale 1ns/10ps
module timer_chk (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic timer_out_pin_a,
   input wire logic timer_out_pin_b,
   input wire logic period_match_flag
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read answer late");
   wr_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   bad_addr_a: assert property (rd_taken ##0 (s_axi_araddr > timer_pkg::ADDR_FLAGS
      || s_axi_araddr[1:0] != 2'h0) |=> s_axi_rresp == timer_pkg::RESP_SLVERR)
      else $error("bad address not refused");
   high_bits_a: assert property (rd_taken ##0 (s_axi_araddr == timer_pkg::ADDR_CNT_HI
      || s_axi_araddr == timer_pkg::ADDR_CMP_HI) |=> s_axi_rdata[31:2] == 30'h0)
      else $error("high byte has extra bits");
   pins_same_a: assert property (timer_out_pin_a == timer_out_pin_b)
      else $error("output pins differ");
   period_gap_a: assert property (period_match_flag |=> !period_match_flag [*8])
      else $error("period matches too close");
endmodule
bind timer_top timer_chk timer_chk_i (.mclk, .rst_n, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
   .timer_out_pin_a, .timer_out_pin_b, .period_match_flag);

// >>> test_standard_timer_module_10bit.sv
// self-checking bench for the ten-bit standard timer
`timescale 1ns/10ps
module test_standard_timer_module_10bit;
   logic mclk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, p, ext_run;
   logic high_speed_clock, time_base_clock, ext_clock_pin, cap_pin_a, cap_pin_b, cap_req;
   logic timer_out_pin_a, timer_out_pin_b, timer_out_en, compare_match_flag, period_match_flag;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   int failures, comparisons, cycles, pf, cf, n, a, b, h;
   int mdl [8];
   int sel_t [7] = '{1, 1, 1, 6, 7, 0, 4};
   int per_t [7] = '{1, 3, 0, 1, 1, 1, 1};
   int ivl_t [7] = '{128, 384, 1024, 1024, 1024, 512, 512};
   // function, compare value, polarity and swap bits, cycles in 128 with pin a high
   int pwm_t [7][4] = '{'{2, 32, 0, 32}, '{2, 200, 0, 128}, '{2, 32, 2, 96}, '{0, 32, 0, 0},
      '{1, 32, 0, 128}, '{2, 64, 1, 128}, '{3, 32, 0, 0}};
   int cap_t [4] = '{1, 1, 2, 0};
   timer_top timer_top_i (.mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .high_speed_clock, .time_base_clock, .ext_clock_pin,
      .cap_pin_a, .cap_pin_b, .timer_out_pin_a, .timer_out_pin_b, .timer_out_en,
      .compare_match_flag, .period_match_flag);
   timer_pins_model timer_pins_model_i (.mclk, .ext_run, .cap_req, .ext_clock_pin, .cap_pin_a,
      .cap_pin_b);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input bit ok, input string m);
      comparisons++;
      if (!ok) begin
         failures++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
      @(posedge mclk);
      s_axi_awaddr <= ad;
      s_axi_wdata <= wd;
      {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
      do begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1));
      s_axi_bready <= 1'b0;
      if (ad == timer_pkg::ADDR_CMP_HI)
         mdl[5] = wd[1:0];
      else if (ad inside {timer_pkg::ADDR_CTRL0, timer_pkg::ADDR_CTRL1, timer_pkg::ADDR_CMP_LO})
         mdl[ad[4:2]] = wd[7:0];
   endtask
   task automatic rd(input logic [7:0] ad);
      @(posedge mclk);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1));
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] ad);
      rd(ad);
      chk(d === 32'(mdl[ad[4:2]]) && r === timer_pkg::RESP_OKAY, "register readback");
   endtask
   task automatic cnt(output int v);
      rd(timer_pkg::ADDR_CNT_LO);
      v = d[7:0];
      rd(timer_pkg::ADDR_CNT_HI);
      v = v + 256 * d[1:0];
   endtask
   task automatic cmpw(input int v);
      wr(timer_pkg::ADDR_CMP_LO, 32'(v % 256));
      wr(timer_pkg::ADDR_CMP_HI, 32'(v / 256));
   endtask
   task automatic run(input logic [7:0] c1, input logic [7:0] c0);
      wr(timer_pkg::ADDR_CTRL0, 32'h0);
      wr(timer_pkg::ADDR_CTRL1, {24'h0, c1});
      wr(timer_pkg::ADDR_CTRL0, {24'h0, c0});
      repeat (3) @(posedge mclk);
   endtask
   // pin level two cycles after a flag, then cycles to the next flag
   task automatic gap(input bit sel, output int v);
      do @(posedge mclk); while ((sel ? compare_match_flag : period_match_flag) !== 1'b1);
      repeat (2) @(posedge mclk);
      p = timer_out_pin_a;
      v = 2;
      do begin
         @(posedge mclk);
         v++;
      end while ((sel ? compare_match_flag : period_match_flag) !== 1'b1 && v < 2000);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #20 mclk = !mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      high_speed_clock <= cycles[0];
      time_base_clock <= cycles[1];
      pf <= pf + int'(period_match_flag === 1'b1);
      cf <= cf + int'(compare_match_flag === 1'b1);
      if (cycles == 40000) begin
         chk(1'b0, "timeout");
         final_report();
      end
   end
   initial begin
      rst_n = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'h1;
      {ext_run, cap_req} = 2'h0;
      void'($urandom(2048));
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      for (int i = 0; i < 7; i++) rchk(8'(i * 4));
      rd(8'h1C);
      chk(r === timer_pkg::RESP_SLVERR, "unmapped read accepted");
      rd(8'h05);
      chk(r === timer_pkg::RESP_SLVERR, "misaligned read accepted");
      repeat (3) begin
         cmpw($urandom % 1024);
         rchk(timer_pkg::ADDR_CMP_LO);
         rchk(timer_pkg::ADDR_CMP_HI);
      end
      wr(timer_pkg::ADDR_CNT_LO, 32'hFF);
      rchk(timer_pkg::ADDR_CNT_LO);
      ext_run <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         run({timer_pkg::MODE_TMR, 6'h0}, {1'b0, 3'(sel_t[i]), 1'b1, 3'(per_t[i])});
         chk(timer_out_en === 1'b0, "pins driven in timer mode");
         gap(1'b0, n);
         chk(n === ivl_t[i], "period interval");
      end
      // high clock toggles every cycle: one tick per 32 or per 128 cycles
      for (int i = 2; i < 4; i++) begin
         run({timer_pkg::MODE_TMR, 6'h0}, {1'b0, 3'(i), 4'h8});
         repeat (640) @(posedge mclk);
         cnt(a);
         chk(i == 2 ? a inside {[19:22]} : a inside {[4:6]}, "divided clock");
      end
      for (int i = 0; i < 3; i++) begin
         wr(timer_pkg::ADDR_CTRL0, 32'h19);
         repeat (40) @(posedge mclk);
         wr(timer_pkg::ADDR_CTRL0, 32'(i == 0 ? 8'h99 : i == 1 ? 8'h59 : 8'h11));
         cnt(a);
         repeat (30) @(posedge mclk);
         cnt(b);
         chk(a === b && a > 0, "counter not held");
      end
      wr(timer_pkg::ADDR_CTRL0, 32'h19);
      cnt(a);
      chk(a < 40, "counter not cleared on start");
      cmpw(200);
      for (int f = 0; f < 4; f++) begin
         run({timer_pkg::MODE_CMP, 2'(f), 4'h9}, 8'h19);
         h = pf;
         chk({timer_out_pin_a, timer_out_en} === 2'h3, "init level");
         gap(1'b1, n);
         chk(p === (f == 1 || f == 3 ? 1'b0 : 1'b1), "match action");
         chk(n === 200, "compare interval");
         repeat (2) @(posedge mclk);
         chk(timer_out_pin_a === (f == 1 ? 1'b0 : 1'b1), "toggle back");
         chk(pf === h, "period flag with compare clear");
      end
      for (int i = 0; i < 7; i++) begin
         cmpw(pwm_t[i][1]);
         run({timer_pkg::MODE_PWM, 2'(pwm_t[i][0]), 1'b1, 2'(pwm_t[i][2]), 1'b0}, 8'h19);
         repeat (300) @(posedge mclk);
         h = 0;
         repeat (128) @(posedge mclk) h += int'(timer_out_pin_a === 1'b1);
         chk(h === pwm_t[i][3], "pwm count");
      end
      for (int f = 3; f >= 0; f--) begin
         cmpw(1000);
         run({timer_pkg::MODE_CAP, 2'(f), 4'h0}, 8'h19);
         h = cf;
         cap_req <= 1'b1;
         @(posedge mclk);
         cap_req <= 1'b0;
         repeat (20) @(posedge mclk);
         chk(cf - h === cap_t[f], "capture flag count");
      end
      rd(timer_pkg::ADDR_CMP_HI);
      chk(d === 32'h0, "captured count missing");
      final_report();
   end
endmodule
